// ### hw/cax_cmd_exec.sv
/*
 * Coordinate and accumulator command executor.
 * Holds the per-axis coordinate array, accumulator and X register.
 * Assumes an external non-volatile store that answers a one-word read
 * in a later cycle, and actual positions presented flat per axis.
 */
`timescale 1ns/100ps

// What this block does
// - Get coordinate in program mode loads accumulator
// - Direct get coordinate replies, accumulator untouched
// - Good get coordinate reply is status 100
// - Persist flag selects RAM or stored coordinates
// - Entry zero never stored nor restored
// - Get 0,255,0 restores entries one to twenty
// - Get n,255 restores one entry, n 1..20
// - Capture writes actual axis position to entry
// - Accu-to-coordinate stores accumulator in entry
// - Calc-with-X: accumulator op X into accumulator
// - Types 0..4 add, sub, mul, div, remainder
// - Types 5..7 and, or, xor
// - Type 8 inverts X
// - Type 9 loads X, 10 swaps
// - Accu-to-axis writes accumulator to axis parameter
module cax_cmd_exec
   import cax_pkg::*;
#(
   parameter int NUM_MOTORS = cax_pkg::CAX_NUM_MOTORS,
   parameter int NUM_COORDS = cax_pkg::CAX_NUM_COORDS
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // Command byte stream
   input  wire logic                   byte_valid,
   input  wire logic [7:0]             byte_data,
   input  wire logic                   frame_abort,
   input  wire logic                   standalone,
   // Global setting for coordinate persistence
   input  wire logic                   persist_set,
   input  wire logic                   persist_val,
   // Actual positions, axis k at [32k+31:32k]
   input  wire logic [NUM_MOTORS*32-1:0] actual_pos,
   // Non-volatile store
   output logic                        nv_rd,
   output logic                        nv_wr,
   output logic [7:0]                  nv_motor,
   output logic [7:0]                  nv_coord,
   output logic [31:0]                 nv_wdata,
   input  wire logic                   nv_rvalid,
   input  wire logic [31:0]            nv_rdata,
   // Axis parameter write
   output logic                        ap_wr,
   output logic [7:0]                  ap_num,
   output logic [7:0]                  ap_motor,
   output logic [31:0]                 ap_data,
   // Reply
   output logic                        reply_valid,
   output logic [7:0]                  reply_status,
   output logic [31:0]                 reply_value,
   output logic                        busy,
   output logic                        persist_mode,
   output logic [31:0]                 accu_out,
   output logic [31:0]                 xreg_out
);
   import cax_pkg::*;

   typedef enum logic [1:0] {
      CAX_IDLE = 2'b00,
      CAX_REQ  = 2'b01,
      CAX_WAIT = 2'b11
   } cax_state_t;

   cax_frame_if frm ();

   cax_frame_rx u_rx (
      .clk         (clk),
      .reset_n     (reset_n),
      .byte_valid  (byte_valid),
      .byte_data   (byte_data),
      .frame_abort (frame_abort),
      .frm         (frm)
   );

   // Coordinate RAM, per motor per entry
   logic [31:0] coord_q [NUM_MOTORS][NUM_COORDS];
   logic [31:0] accu_q;       // Accumulator
   logic [31:0] x_q;          // X register
   logic        persist_q;    // Persistence setting
   cax_state_t  st_q;         // Restore sequencer
   logic [7:0]  rmot_q;       // Restore motor index
   logic [7:0]  rcrd_q;       // Restore coordinate index
   logic        rall_q;       // Restoring all entries
   logic        rvld_q;
   logic [7:0]  rst_q;
   logic [31:0] rval_q;
   logic        nvrd_q;
   logic        nvwr_q;
   logic [7:0]  nvm_q;
   logic [7:0]  nvc_q;
   logic [31:0] nvw_q;
   logic        apwr_q;
   logic [7:0]  apn_q;
   logic [7:0]  apm_q;
   logic [31:0] apd_q;

   // Field decode
   wire [7:0] op   = frm.opcode;
   wire [7:0] crd  = frm.typ;
   wire [7:0] mot  = frm.motor;
   wire       take = frm.valid && frm.sum_ok && (st_q == CAX_IDLE);
   wire       is_coord_op = (op == CAX_OP_GET_COORD) ||
                            (op == CAX_OP_CAPTURE_POS) ||
                            (op == CAX_OP_ACCU_COORD);
   wire       motor_store = (mot == CAX_MOTOR_STORE);
   // Range check, 255 only special for get coordinate
   wire       crd_bad = (crd > CAX_MAX_COORD);
   wire       mot_bad = (mot > CAX_MAX_MOTOR) &&
                        !(motor_store && op == CAX_OP_GET_COORD);
   wire       coord_bad = is_coord_op && (crd_bad || mot_bad);
   wire       restore_req = take && !coord_bad &&
                            op == CAX_OP_GET_COORD && motor_store;
   wire [31:0] coord_rd = coord_q[mot[2:0]][crd[4:0]];
   wire [31:0] pos_sel  = actual_pos[32*mot[2:0] +: 32];
   wire        known_op = is_coord_op || op == CAX_OP_CALC_X ||
                          op == CAX_OP_ACCU_AXIS;

   // Calc-with-X result; division by zero leaves accumulator
   wire        x_zero = (x_q == 32'h0000_0000);
   wire signed [31:0] a_s = accu_q;
   wire signed [31:0] x_s = x_q;
   wire [63:0] prod = 64'(a_s * x_s);
   logic [31:0] calc_res;
   always_comb begin
      calc_res = accu_q;
      case (crd)
         CAX_CX_ADD: calc_res = accu_q + x_q;
         CAX_CX_SUB: calc_res = accu_q - x_q;
         CAX_CX_MUL: calc_res = prod[31:0];
         CAX_CX_DIV: calc_res = x_zero ? a_s : a_s / x_s;
         CAX_CX_REM: calc_res = x_zero ? a_s : a_s % x_s;
         CAX_CX_AND: calc_res = accu_q & x_q;
         CAX_CX_OR:  calc_res = accu_q | x_q;
         CAX_CX_XOR: calc_res = accu_q ^ x_q;
         CAX_CX_SWAP: calc_res = x_q;
         default:    calc_res = accu_q;
      endcase
   end
   wire calc_type_ok = (crd <= CAX_CX_SWAP);

   // Persistence setting, RAM only after reset
   always_ff @(posedge clk) begin
      if (!reset_n)         persist_q <= CAX_PERSIST_RST;
      else if (persist_set) persist_q <= persist_val;
   end

   // Accumulator and X register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         accu_q <= 32'h0000_0000;
         x_q    <= 32'h0000_0000;
      end else if (take && !coord_bad) begin
         if (op == CAX_OP_GET_COORD && !motor_store && standalone)
            accu_q <= coord_rd;                   // Program mode
         else if (op == CAX_OP_CALC_X && calc_type_ok) begin
            accu_q <= calc_res;
            if (crd == CAX_CX_NOT)  x_q <= ~x_q;
            if (crd == CAX_CX_LOAD) x_q <= accu_q;
            if (crd == CAX_CX_SWAP) x_q <= accu_q;
         end
      end
   end

   // Coordinate array writes; restore never touches entry zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int m = 0; m < NUM_MOTORS; m++)
            for (int c = 0; c < NUM_COORDS; c++)
               coord_q[m][c] <= 32'h0000_0000;
      end else if (take && !coord_bad && !motor_store) begin
         if (op == CAX_OP_CAPTURE_POS)
            coord_q[mot[2:0]][crd[4:0]] <= pos_sel;
         else if (op == CAX_OP_ACCU_COORD)
            coord_q[mot[2:0]][crd[4:0]] <= accu_q;
      end else if (st_q == CAX_WAIT && nv_rvalid && rcrd_q != 8'h00)
         coord_q[rmot_q[2:0]][rcrd_q[4:0]] <= nv_rdata;
   end

   // Restore sequencer: walks motors and entries from the store
   wire last_mot = (rmot_q == 8'(NUM_MOTORS - 1));
   wire last_crd = (rcrd_q == CAX_MAX_COORD);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q   <= CAX_IDLE;
         rmot_q <= 8'h00;
         rcrd_q <= 8'h01;
         rall_q <= 1'b0;
      end else begin
         case (st_q)
            CAX_IDLE: if (restore_req) begin
               rall_q <= (crd == 8'h00);
               rcrd_q <= (crd == 8'h00) ? 8'h01 : crd; // Skip zero
               rmot_q <= 8'h00;
               st_q   <= CAX_REQ;
            end
            CAX_REQ:  st_q <= CAX_WAIT;
            CAX_WAIT: if (nv_rvalid) begin
               if (!last_mot) begin
                  rmot_q <= rmot_q + 8'h01;
                  st_q   <= CAX_REQ;
               end else if (rall_q && !last_crd) begin
                  rmot_q <= 8'h00;
                  rcrd_q <= rcrd_q + 8'h01;
                  st_q   <= CAX_REQ;
               end else
                  st_q <= CAX_IDLE;
            end
            default:  st_q <= CAX_IDLE;
         endcase
      end
   end

   // Store port: reads for restore, writes mirror when persisting
   wire mirror = take && !coord_bad && persist_q && !motor_store &&
                 crd != 8'h00 && (op == CAX_OP_CAPTURE_POS ||
                 op == CAX_OP_ACCU_COORD);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         nvrd_q <= 1'b0;
         nvwr_q <= 1'b0;
         nvm_q  <= 8'h00;
         nvc_q  <= 8'h00;
         nvw_q  <= 32'h0000_0000;
      end else begin
         nvrd_q <= (st_q == CAX_REQ);
         nvwr_q <= mirror;
         nvm_q  <= (st_q == CAX_REQ) ? rmot_q : mot;
         nvc_q  <= (st_q == CAX_REQ) ? rcrd_q : crd;
         nvw_q  <= (op == CAX_OP_CAPTURE_POS) ? pos_sel : accu_q;
      end
   end

   // Axis parameter transfer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         apwr_q <= 1'b0;
         apn_q  <= 8'h00;
         apm_q  <= 8'h00;
         apd_q  <= 32'h0000_0000;
      end else begin
         apwr_q <= take && op == CAX_OP_ACCU_AXIS && mot <= CAX_MAX_MOTOR;
         apn_q  <= crd;
         apm_q  <= mot;
         apd_q  <= accu_q;
      end
   end

   // Reply, one per frame; busy frames answer with a command error
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rvld_q <= 1'b0;
         rst_q  <= 8'h00;
         rval_q <= 32'h0000_0000;
      end else begin
         rvld_q <= frm.valid;
         rval_q <= 32'h0000_0000;
         if (!frm.sum_ok)                   rst_q <= CAX_ST_BAD_SUM;
         else if (st_q != CAX_IDLE || !known_op) rst_q <= CAX_ST_BAD_CMD;
         else if (coord_bad)                rst_q <= CAX_ST_BAD_VAL;
         else if (op == CAX_OP_CALC_X && !calc_type_ok)
            rst_q <= CAX_ST_BAD_TYPE;
         else if (op == CAX_OP_ACCU_AXIS && mot > CAX_MAX_MOTOR)
            rst_q <= CAX_ST_BAD_VAL;
         else begin
            rst_q <= CAX_ST_OK;
            if (op == CAX_OP_GET_COORD && !motor_store)
               rval_q <= coord_rd;
            else if (op == CAX_OP_CAPTURE_POS)
               rval_q <= pos_sel;
         end
      end
   end

   // Registered status outputs
   logic busy_q;
   always_ff @(posedge clk) begin
      if (!reset_n) busy_q <= 1'b0;
      else          busy_q <= (st_q != CAX_IDLE) || restore_req;
   end

   assign nv_rd        = nvrd_q;
   assign nv_wr        = nvwr_q;
   assign nv_motor     = nvm_q;
   assign nv_coord     = nvc_q;
   assign nv_wdata     = nvw_q;
   assign ap_wr        = apwr_q;
   assign ap_num       = apn_q;
   assign ap_motor     = apm_q;
   assign ap_data      = apd_q;
   assign reply_valid  = rvld_q;
   assign reply_status = rst_q;
   assign reply_value  = rval_q;
   assign busy         = busy_q;
   assign persist_mode = persist_q;
   assign accu_out     = accu_q;
   assign xreg_out     = x_q;
endmodule

// ### hw/cax_frame_if.sv
/*
 * Carrier between the frame assembler and the executor.
 * Assumes both sides share clk.
 */
`timescale 1ns/100ps
interface cax_frame_if;
   logic        valid;   // One-cycle pulse, whole frame present
   logic        sum_ok;  // Checksum matched
   logic [7:0]  opcode;  // Instruction byte
   logic [7:0]  typ;     // Type byte
   logic [7:0]  motor;   // Motor/bank byte
   logic [31:0] value;   // Value, assembled MSB first
   modport src (output valid, sum_ok, opcode, typ, motor, value);
   modport dst (input  valid, sum_ok, opcode, typ, motor, value);
endinterface

// ### hw/cax_frame_rx.sv
/*
 * Frame assembler: collects nine bytes and checks the modulo-256 sum.
 * Assumes bytes arrive as one-cycle strobes on clk from same-domain logic.
 */
`timescale 1ns/100ps
module cax_frame_rx
   import cax_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Byte stream
   input  wire logic       byte_valid,
   input  wire logic [7:0] byte_data,
   input  wire logic       frame_abort,
   // Assembled frame
   cax_frame_if.src        frm
);
   logic [3:0]  idx_q;   // Byte position in frame
   logic [7:0]  sum_q;   // Running checksum
   logic [7:0]  op_q;    // Captured instruction
   logic [7:0]  typ_q;   // Captured type
   logic [7:0]  mot_q;   // Captured motor
   logic [31:0] val_q;   // Captured value
   logic        vld_q;   // Frame-ready pulse
   logic        ok_q;    // Checksum result

   wire last_byte = byte_valid && (idx_q == 4'(CAX_FRAME_BYTES - 1));

   // Byte collection; address byte only feeds the sum
   always_ff @(posedge clk) begin
      if (!reset_n || frame_abort) begin
         idx_q <= 4'h0;
         sum_q <= 8'h00;
         vld_q <= 1'b0;
         ok_q  <= 1'b0;
      end else begin
         vld_q <= last_byte;
         if (byte_valid) begin
            if (last_byte) begin
               ok_q  <= (byte_data == sum_q); // Sum of first eight
               idx_q <= 4'h0;
               sum_q <= 8'h00;
            end else begin
               idx_q <= idx_q + 4'h1;
               sum_q <= sum_q + byte_data;
            end
         end
      end
   end

   // Field capture by position, value most significant first
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         op_q  <= 8'h00;
         typ_q <= 8'h00;
         mot_q <= 8'h00;
         val_q <= 32'h0000_0000;
      end else if (byte_valid) begin
         case (idx_q)
            4'h1:    op_q  <= byte_data;
            4'h2:    typ_q <= byte_data;
            4'h3:    mot_q <= byte_data;
            4'h4, 4'h5, 4'h6, 4'h7: val_q <= {val_q[23:0], byte_data};
            default: ;
         endcase
      end
   end

   assign frm.valid  = vld_q;
   assign frm.sum_ok = ok_q;
   assign frm.opcode = op_q;
   assign frm.typ    = typ_q;
   assign frm.motor  = mot_q;
   assign frm.value  = val_q;
endmodule

// ### hw/cax_pkg.sv
/*
 * Package for the coordinate/accumulator command executor.
 * Assumes a single 100 MHz clock domain and a host or program sequencer
 * that presents decoded command frames as bytes.
 */
package cax_pkg;
   // Frame shape
   localparam int        CAX_FRAME_BYTES = 9;
   localparam int        CAX_VAL_BYTES   = 4;
   // Opcodes
   localparam logic [7:0] CAX_OP_GET_COORD   = 8'h1F; // 31
   localparam logic [7:0] CAX_OP_CAPTURE_POS = 8'h20; // 32
   localparam logic [7:0] CAX_OP_CALC_X      = 8'h21; // 33
   localparam logic [7:0] CAX_OP_ACCU_AXIS   = 8'h22; // 34
   localparam logic [7:0] CAX_OP_ACCU_COORD  = 8'h27; // 39
   // Calc-with-X type codes
   localparam logic [7:0] CAX_CX_ADD  = 8'h00;
   localparam logic [7:0] CAX_CX_SUB  = 8'h01;
   localparam logic [7:0] CAX_CX_MUL  = 8'h02;
   localparam logic [7:0] CAX_CX_DIV  = 8'h03;
   localparam logic [7:0] CAX_CX_REM  = 8'h04;
   localparam logic [7:0] CAX_CX_AND  = 8'h05;
   localparam logic [7:0] CAX_CX_OR   = 8'h06;
   localparam logic [7:0] CAX_CX_XOR  = 8'h07;
   localparam logic [7:0] CAX_CX_NOT  = 8'h08;
   localparam logic [7:0] CAX_CX_LOAD = 8'h09;
   localparam logic [7:0] CAX_CX_SWAP = 8'h0A;
   // Limits and special values
   localparam logic [7:0] CAX_MAX_COORD   = 8'h14; // 20
   localparam logic [7:0] CAX_MAX_MOTOR   = 8'h05;
   localparam logic [7:0] CAX_MOTOR_STORE = 8'hFF; // 255
   localparam int         CAX_NUM_MOTORS  = 6;
   localparam int         CAX_NUM_COORDS  = 21;
   // Reply status codes
   localparam logic [7:0] CAX_ST_OK       = 8'h64; // 100
   localparam logic [7:0] CAX_ST_BAD_SUM  = 8'h01;
   localparam logic [7:0] CAX_ST_BAD_CMD  = 8'h02;
   localparam logic [7:0] CAX_ST_BAD_TYPE = 8'h03;
   localparam logic [7:0] CAX_ST_BAD_VAL  = 8'h04;
   // Global parameter number for persistent coordinates
   localparam logic [7:0] CAX_GP_PERSIST  = 8'h54; // 84
   localparam logic       CAX_PERSIST_RST = 1'b0;  // RAM only
endpackage

// ### tb/cax_cmd_monitor.sv
/*
 * Checker for the coordinate/accumulator command executor.
 * Assumes it sees only the top ports and that frames restart at byte 0
 * after reset or abort, as the receiver does.
 */
`timescale 1ns/100ps
module cax_cmd_monitor
   import cax_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Command side
   input  wire logic        byte_valid,
   input  wire logic [7:0]  byte_data,
   input  wire logic        frame_abort,
   input  wire logic        standalone,
   input  wire logic        persist_set,
   input  wire logic        persist_val,
   // Results
   input  wire logic        nv_rd,
   input  wire logic        nv_wr,
   input  wire logic [7:0]  nv_coord,
   input  wire logic        ap_wr,
   input  wire logic        reply_valid,
   input  wire logic [7:0]  reply_status,
   input  wire logic [31:0] reply_value,
   input  wire logic        busy,
   input  wire logic        persist_mode,
   input  wire logic [31:0] accu_out,
   input  wire logic [31:0] xreg_out
);
   logic [3:0] pos_q;  // Byte position in frame
   logic [7:0] op_q;   // Latched opcode
   logic [7:0] typ_q;  // Latched type
   logic [7:0] mot_q;  // Latched motor
   wire        last_w = byte_valid && pos_q == 4'h8;  // Checksum byte
   wire        get_w  = last_w && op_q == CAX_OP_GET_COORD;
   wire        swap_w = last_w && op_q == CAX_OP_CALC_X
                        && typ_q == CAX_CX_SWAP;

   // Frame position, mirrors the receiver
   always_ff @(posedge clk) begin
      if (!reset_n || frame_abort) begin
         pos_q <= 4'h0;
      end else if (byte_valid) begin
         pos_q <= last_w ? 4'h0 : pos_q + 4'h1;
      end
   end
   // Header bytes kept for the frame's end
   always_ff @(posedge clk) begin
      if (byte_valid && pos_q == 4'h1) op_q <= byte_data;
      if (byte_valid && pos_q == 4'h2) typ_q <= byte_data;
      if (byte_valid && pos_q == 4'h3) mot_q <= byte_data;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_nv_wr_no_zero; nv_wr |-> nv_coord != 8'h00; endproperty
   a_nv_wr_no_zero: assert property (p_nv_wr_no_zero)
      else $error("Store write to entry zero");
   property p_nv_rd_range;
      nv_rd |-> nv_coord inside {[8'h01:CAX_MAX_COORD]};
   endproperty
   a_nv_rd_range: assert property (p_nv_rd_range)
      else $error("Restore read outside entries one to twenty");
   property p_nv_wr_persist; nv_wr |-> persist_mode && reply_valid;
   endproperty
   a_nv_wr_persist: assert property (p_nv_wr_persist)
      else $error("Store write without persistence or reply");
   property p_persist_load;
      persist_set |=> persist_mode == $past(persist_val);
   endproperty
   a_persist_load: assert property (p_persist_load)
      else $error("Persistence setting not loaded");
   property p_ap_wr_ok;
      ap_wr |-> reply_valid && reply_status == CAX_ST_OK;
   endproperty
   a_ap_wr_ok: assert property (p_ap_wr_ok)
      else $error("Axis write without good reply");
   property p_frame_reply; last_w |-> ##2 reply_valid ##1 !reply_valid;
   endproperty
   a_frame_reply: assert property (p_frame_reply)
      else $error("Reply not one pulse two cycles after frame");
   property p_direct_get; get_w && !standalone |-> ##2 $stable(accu_out);
   endproperty
   a_direct_get: assert property (p_direct_get)
      else $error("Direct get changed accumulator");
   property p_prog_get;
      get_w && standalone && mot_q != CAX_MOTOR_STORE |-> ##2
         (reply_status != CAX_ST_OK || accu_out == reply_value);
   endproperty
   a_prog_get: assert property (p_prog_get)
      else $error("Program get did not load accumulator");
   property p_swap;
      swap_w |-> ##2 (reply_status != CAX_ST_OK ||
         (accu_out == $past(xreg_out) && xreg_out == $past(accu_out)));
   endproperty
   a_swap: assert property (p_swap)
      else $error("Swap did not exchange accumulator and X");
   property p_restore_start; $rose(busy) |-> ##1 nv_rd; endproperty
   a_restore_start: assert property (p_restore_start)
      else $error("Restore did not issue first read");

   // Main scenarios reached
   c_axis_write: cover property (ap_wr);
   c_store_write: cover property (nv_wr);
   c_restore: cover property ($rose(busy));
endmodule

bind cax_cmd_exec cax_cmd_monitor u_cax_cmd_monitor (.*);

// ### tb/cax_nv_model.sv
/*
 * Behavioural non-volatile coordinate store.
 * Assumes registered one-cycle read and write strobes from the executor.
 */
`timescale 1ns/100ps
module cax_nv_model
   import cax_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Requests
   input  wire logic        nv_rd,
   input  wire logic        nv_wr,
   input  wire logic [7:0]  nv_motor,
   input  wire logic [7:0]  nv_coord,
   input  wire logic [31:0] nv_wdata,
   // Answer
   output logic             nv_rvalid,
   output logic [31:0]      nv_rdata
);
   logic [31:0] mem [CAX_NUM_MOTORS][CAX_NUM_COORDS]; // Stored words
   logic [31:0] pend;  // Word waiting to be returned
   logic        slow;  // Alternates prompt and slow answers
   int          cnt;   // Cycles left before answer

   // Preset pattern, recomputed by the bench
   initial begin
      for (int m = 0; m < CAX_NUM_MOTORS; m++)
         for (int c = 0; c < CAX_NUM_COORDS; c++)
            mem[m][c] = {16'hA5A5, 8'(m), 8'(c)};
      nv_rvalid = 1'b0;
      nv_rdata = 32'h0;
      slow = 1'b0;
      cnt = 0;
   end
   // Store behaviour; data line churns when not answering
   always @(posedge clk) begin
      nv_rvalid <= !nv_rd && cnt == 1;
      nv_rdata <= (!nv_rd && cnt == 1) ? pend : ~nv_rdata;
      if (nv_wr) mem[nv_motor][nv_coord] <= nv_wdata;
      if (nv_rd) begin
         pend = mem[nv_motor][nv_coord];
         cnt = slow ? 6 : 1;
         slow = ~slow;
      end else if (cnt > 0)
         cnt = cnt - 1;
   end
endmodule

// ### tb/coordinate_accumulator_cmd_exec_test.sv
/*
 * Self-checking bench for the command executor.
 * Assumes the store model answers restore reads; 100 MHz clock.
 */
`timescale 1ns/100ps
module coordinate_accumulator_cmd_exec_test;
   import cax_pkg::*;
   logic         clk, reset_n, byte_valid, frame_abort, standalone;
   logic         persist_set, persist_val, nv_rd, nv_wr, nv_rvalid;
   logic         ap_wr, reply_valid, busy, persist_mode;
   logic [7:0]   byte_data, nv_motor, nv_coord, ap_num, ap_motor;
   logic [7:0]   reply_status, st;
   logic [31:0]  nv_wdata, nv_rdata, ap_data, reply_value, accu_out;
   logic [31:0]  xreg_out, rv;
   logic [191:0] actual_pos;
   int           fails, n_compared;

   // Device and store
   cax_cmd_exec u_cax_cmd_exec (.*);
   cax_nv_model u_cax_nv_model (.*);

   always #5 clk = ~clk;

   function automatic logic [31:0] pos_of(int k);
      return 32'h1000_0000 * (k + 1) + 32'd7 * k;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic expst(input logic [7:0] e);
      check(32'(st), 32'(e));
   endtask
   // One frame, optional checksum damage, then wait for reply
   task automatic send(input logic [7:0] op, typ, mot,
                       input logic [31:0] val, input logic [7:0] bad = 0);
      logic [7:0] b [9];
      b = '{8'h01, op, typ, mot, val[31:24], val[23:16], val[15:8],
            val[7:0], bad};
      @(posedge clk);
      for (int i = 0; i < 8; i++) b[8] += b[i];
      for (int i = 0; i < 9; i++) begin
         byte_valid <= 1'b1;
         byte_data <= b[i];
         @(posedge clk);
      end
      byte_valid <= 1'b0;
      st = 8'hEE;
      for (int k = 0; k < 10; k++) begin
         @(posedge clk);
         #1;
         if (reply_valid) break;
      end
      if (reply_valid !== 1'b1) begin
         fails++;
         $display("Error at %0t: reply %h expected %h", $time, 0, 1);
      end
      st = reply_status;
      rv = reply_value;
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
   endtask
   task automatic t_get();
      send(CAX_OP_CAPTURE_POS, 8'h03, 8'h02, 0);
      check(rv, pos_of(2));
      send(CAX_OP_GET_COORD, 8'h03, 8'h02, 0);
      expst(CAX_ST_OK);
      check(rv, pos_of(2));
      check(accu_out, 32'h0);
      standalone <= 1'b1;
      send(CAX_OP_GET_COORD, 8'h03, 8'h02, 0);
      check(accu_out, pos_of(2));
   endtask
   task automatic t_calc();
      logic [31:0] a, b, e;
      a = 32'd1000;
      b = 32'd7;
      actual_pos[63:0] <= {b, a};
      send(CAX_OP_CAPTURE_POS, 8'h01, 8'h00, 0);
      send(CAX_OP_CAPTURE_POS, 8'h01, 8'h01, 0);
      send(CAX_OP_GET_COORD, 8'h01, 8'h01, 0);
      send(CAX_OP_CALC_X, CAX_CX_LOAD, 8'h00, 0);
      check(xreg_out, b);
      for (int t = 0; t < 8; t++) begin
         send(CAX_OP_GET_COORD, 8'h01, 8'h00, 0);
         send(CAX_OP_CALC_X, 8'(t), 8'h00, 0);
         case (t)
            0: e = a + b;
            1: e = a - b;
            2: e = a * b;
            3: e = a / b;
            4: e = a % b;
            5: e = a & b;
            6: e = a | b;
            default: e = a ^ b;
         endcase
         check(accu_out, e);
      end
      send(CAX_OP_CALC_X, CAX_CX_NOT, 8'h00, 0);
      check(xreg_out, ~b);
      send(CAX_OP_CALC_X, CAX_CX_NOT, 8'h00, 0);
      send(CAX_OP_GET_COORD, 8'h01, 8'h00, 0);
      send(CAX_OP_CALC_X, CAX_CX_SWAP, 8'h00, 0);
      check({accu_out, xreg_out}, {b, a});
      send(CAX_OP_CALC_X, 8'h0B, 8'h00, 0);
      expst(CAX_ST_BAD_TYPE);
      send(CAX_OP_ACCU_AXIS, 8'h05, 8'h04, 0);
      check({7'h0, ap_wr, ap_num, ap_motor, 8'h0}, 32'h0105_0400);
      check(ap_data, b);
      send(CAX_OP_ACCU_COORD, 8'h14, 8'h05, 0);
      standalone <= 1'b0;
      send(CAX_OP_GET_COORD, 8'h14, 8'h05, 0);
      check(rv, b);
   endtask
   task automatic t_store();
      check(32'(persist_mode), 32'h0);
      persist_val <= 1'b1;
      persist_set <= 1'b1;
      @(posedge clk);
      persist_set <= 1'b0;
      @(posedge clk);
      #1;
      check(32'(persist_mode), 32'h1);
      send(CAX_OP_CAPTURE_POS, 8'h00, 8'h00, 0);
      send(CAX_OP_CAPTURE_POS, 8'h02, 8'h03, 0);
      check(32'({nv_wr, nv_motor, nv_coord}), 32'h1_0302);
      check(nv_wdata, pos_of(3));
      send(CAX_OP_GET_COORD, 8'h07, CAX_MOTOR_STORE, 0);
      wait_idle();
      for (int m = 0; m < 6; m++) begin
         send(CAX_OP_GET_COORD, 8'h07, 8'(m), 0);
         check(rv, {16'hA5A5, 8'(m), 8'h07});
      end
      send(CAX_OP_GET_COORD, 8'h00, CAX_MOTOR_STORE, 0);
      expst(CAX_ST_OK);
      send(CAX_OP_GET_COORD, 8'h01, 8'h00, 0);
      expst(CAX_ST_BAD_CMD);
      wait_idle();
      send(CAX_OP_GET_COORD, 8'h00, 8'h00, 0);
      check(rv, 32'd1000);
      send(CAX_OP_GET_COORD, 8'h14, 8'h05, 0);
      check(rv, 32'hA5A5_0514);
      send(CAX_OP_GET_COORD, 8'h02, 8'h03, 0);
      check(rv, pos_of(3));
   endtask
   task automatic t_errors();
      send(CAX_OP_GET_COORD, 8'h01, 8'h00, 0, 8'h01);
      expst(CAX_ST_BAD_SUM);
      send(CAX_OP_GET_COORD, 8'h15, 8'h00, 0);
      expst(CAX_ST_BAD_VAL);
      send(CAX_OP_CAPTURE_POS, 8'h01, 8'h06, 0);
      expst(CAX_ST_BAD_VAL);
      send(CAX_OP_GET_COORD, 8'h15, CAX_MOTOR_STORE, 0);
      expst(CAX_ST_BAD_VAL);
      // Partial frame thrown away by abort
      byte_valid <= 1'b1;
      byte_data <= 8'h01;
      repeat (3) @(posedge clk);
      byte_valid <= 1'b0;
      frame_abort <= 1'b1;
      @(posedge clk);
      frame_abort <= 1'b0;
      send(CAX_OP_GET_COORD, 8'h14, 8'h05, 0);
      expst(CAX_ST_OK);
   endtask
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      {byte_valid, frame_abort, standalone} = 3'b000;
      {persist_set, persist_val, byte_data} = 10'h0;
      for (int k = 0; k < 6; k++) actual_pos[32*k +: 32] = pos_of(k);
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_get();
      t_calc();
      t_store();
      t_errors();
      end_of_test();
   end
   // Watchdog, far beyond the roughly 1,400 cycles needed
   initial begin
      #100000;
      fails++;
      $display("Error at %0t: watchdog %h expected %h", $time, 1, 0);
      end_of_test();
   end
endmodule
